// *** logic/csc_pkg.sv ***
// current sense control: shared constants, register map and types
// assumes a 100 MHz system clock and a 32-bit classic wishbone bus
package csc_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 10; // clock period
    localparam int SETTLE_NS = 2000; // sense settling time after turn-on
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS; // round up
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] GEN_CFG_ADR = 8'h00; // general_config_register
    localparam logic [7:0] RETRY0_ADR = 8'h04; // channel_retry_register, ch 0
    localparam logic [7:0] RETRY1_ADR = 8'h08; // channel_retry_register, ch 1
    localparam logic [7:0] OC_CFG_ADR = 8'h0C; // overcurrent_config_register
    localparam logic [7:0] STATUS_ADR = 8'h10; // live state, read only
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int SEL_A_POS = 0; // sense_select_bit_a
    localparam int SEL_B_POS = 1; // sense_select_bit_b
    localparam int TH_EN_POS = 2; // track-and-hold enable
    localparam int OFP_POS = 8; // offset_polarity_bit
    localparam int RATIO_POS = 0; // 1 selects low_current_ratio
    // ----------------------------------------
    // reset values and levels
    // ----------------------------------------
    localparam logic [2:0] GEN_CFG_RST = 3'h0; // synchronous sensing, nothing routed
    localparam logic OFP_RST = 1'b0;
    localparam logic RATIO_RST = 1'b0; // high_current_ratio
    localparam logic [11:0] OCL_HIGH = 12'hC00; // lower_overcurrent_threshold, high ratio
    localparam logic [11:0] OCL_LOW = 12'h400; // lowered with low_current_ratio
    localparam int RATIO_SHIFT = 2; // high ratio scales the mirror down
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        CSC_SRC_NONE = 2'b00,
        CSC_SRC_CH0 = 2'b01,
        CSC_SRC_CH1 = 2'b10,
        CSC_SRC_TEMP = 2'b11
    } csc_src_type;
    typedef enum logic [1:0] {
        CSC_IDLE = 2'b00, // no channel current on the sense output
        CSC_SETTLE = 2'b01, // channel on, waiting for settling
        CSC_VALID = 2'b10, // live current valid, sync pin low
        CSC_HOLD = 2'b11 // held sample shown during off time
    } csc_state_type;
    typedef struct packed {
        logic th_en; // track-and-hold enable
        csc_src_type src; // {sense_select_bit_b, sense_select_bit_a}
    } csc_cfg_type;
endpackage : csc_pkg

// *** logic/csc_top.sv ***
// current sense control: routing, sync/track-and-hold sequencing,
// sense ratio and offset polarity, wishbone register slave
// assumes analog quantities arrive digitised and synchronous to clk_i
//
// Behaviour
// - route channel current or temperature per select
// - overcurrent window disables sensing, sync high
// - track-and-hold bit picks sync or hold mode
// - track-and-hold bit resets to zero
// - sync mode: no current after switch-off
// - sync pin low once settled, until off
// - hold mode samples last current at off
// - hold mode drives sync pin high at off
// - channel change discards held sample
// - ratio bit scales sense, lowers threshold
// - sense only up to lower overcurrent threshold
// - offset polarity one adds, zero subtracts
// - held sample ignores later polarity changes
`timescale 1ns/1ns
`default_nettype none
module csc_top import csc_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // channel side
    input wire logic [1:0] channel_on_i,
    input wire logic [1:0] overcurrent_window_i,
    input wire logic [11:0] load_current_0_i,
    input wire logic [11:0] load_current_1_i,
    input wire logic [11:0] temperature_i,
    input wire logic [7:0] random_offset_i,
    // sense pins
    output logic [11:0] sense_value_o,
    output logic sense_valid_pin_inverted_o,
    output logic [11:0] lower_overcurrent_threshold_o
);
    // ----------------------------------------
    // register decode
    // ----------------------------------------
    // word index of a byte address, 7 means unmapped
    function automatic logic [2:0] reg_idx(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h7;
        if (a == GEN_CFG_ADR) r = 3'h0;
        if (a == RETRY0_ADR) r = 3'h1;
        if (a == RETRY1_ADR) r = 3'h2;
        if (a == OC_CFG_ADR) r = 3'h3;
        if (a == STATUS_ADR) r = 3'h4;
        return r;
    endfunction : reg_idx

    csc_cfg_type cfg_reg, cfg_next; // general configuration
    logic [1:0] ofp_reg, ofp_next; // per-channel offset polarity
    logic ratio_reg, ratio_next; // low_current_ratio when set
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    csc_state_type state_reg, state_next;
    logic [11:0] held_reg, held_next; // track-and-hold sample
    logic held_ok_reg, held_ok_next;
    logic [11:0] live_reg, live_next; // last observed channel sense
    logic [11:0] sense_reg, sense_next;
    logic sync_reg, sync_next;
    logic [11:0] thr_reg, thr_next;
    logic [$clog2(SETTLE_CYC)-1:0] cnt_reg, cnt_next;
    logic [1:0] on_prev_reg; // for turn-on edges
    csc_src_type src_prev_reg; // for channel-change detection
    logic wr; // write takes effect at the ack edge
    logic [2:0] idx;

    // ----------------------------------------
    // bus and configuration, next values
    // ----------------------------------------
    always_comb begin
        idx = reg_idx(adr_i);
        wr = cyc_i && stb_i && we_i && ack_reg;
        ack_next = cyc_i && stb_i && !ack_reg; // one-cycle ack, then drop
        cfg_next = cfg_reg;
        ofp_next = ofp_reg;
        ratio_next = ratio_reg;
        rdat_next = 32'h0; // unmapped reads return zero
        if (wr && sel_i[0]) begin
            case (idx)
                3'h0: cfg_next = csc_cfg_type'(dat_i[2:0]);
                3'h3: ratio_next = dat_i[RATIO_POS];
                default: ; // no byte-0 field elsewhere
            endcase
        end
        if (wr && sel_i[1]) begin
            case (idx)
                3'h1: ofp_next[0] = dat_i[OFP_POS];
                3'h2: ofp_next[1] = dat_i[OFP_POS];
                default: ; // no byte-1 field elsewhere
            endcase
        end
        case (idx)
            3'h0: rdat_next[2:0] = cfg_reg;
            3'h1: rdat_next[OFP_POS] = ofp_reg[0];
            3'h2: rdat_next[OFP_POS] = ofp_reg[1];
            3'h3: rdat_next[RATIO_POS] = ratio_reg;
            // sync pin, held flag, state, sense value
            3'h4: rdat_next[15:0] = {sense_reg, state_reg, held_ok_reg, sync_reg};
            default: ; // unmapped, stays zero
        endcase
    end

    // bus and configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= csc_cfg_type'(GEN_CFG_RST);
            ofp_reg <= {2{OFP_RST}};
            ratio_reg <= RATIO_RST;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            cfg_reg <= cfg_next;
            ofp_reg <= ofp_next;
            ratio_reg <= ratio_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    // ----------------------------------------
    // sense path
    // ----------------------------------------
    logic cur_sel, ch, on, oc, on_rise, src_chg;
    logic [11:0] cur, thr;
    logic [12:0] adj; // offset-corrected current with carry
    logic [11:0] scaled;

    // live sense value of the monitored channel
    always_comb begin
        cur_sel = (cfg_reg.src == CSC_SRC_CH0) || (cfg_reg.src == CSC_SRC_CH1);
        ch = (cfg_reg.src == CSC_SRC_CH1);
        on = channel_on_i[ch];
        oc = overcurrent_window_i[ch] && cur_sel;
        on_rise = on && !on_prev_reg[ch];
        src_chg = cfg_reg.src != src_prev_reg;
        cur = ch ? load_current_1_i : load_current_0_i;
        thr = ratio_reg ? OCL_LOW : OCL_HIGH;
        if (ofp_reg[ch]) begin
            adj = {1'b0, cur} + {5'h00, random_offset_i};
        end else begin
            adj = {1'b0, cur} - {5'h00, random_offset_i};
        end
        if (cur > thr) begin
            adj = 13'h0000;
        end else if (!ofp_reg[ch] && adj[12]) begin
            adj = 13'h0000; // clamp underflow
        end else if (adj[12]) begin
            adj = 13'h0FFF; // clamp overflow
        end
        // high ratio mirrors less current per amp
        scaled = ratio_reg ? adj[11:0] : (adj[11:0] >> RATIO_SHIFT);
        live_next = scaled;
        thr_next = thr;
    end

    // ----------------------------------------
    // sensing sequence
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        held_next = held_reg;
        held_ok_next = held_ok_reg;
        if (src_chg || !cur_sel || oc) begin
            // leftover hold charge belongs to the old source
            state_next = CSC_IDLE;
            held_ok_next = src_chg ? 1'b0 : held_ok_reg;
        end else begin
            case (state_reg)
                CSC_IDLE: begin
                    // only a fresh turn-on starts a measurement
                    if (on_rise) begin
                        state_next = CSC_SETTLE;
                        cnt_next = '0;
                    end
                end
                CSC_SETTLE: begin
                    if (!on) begin
                        state_next = cfg_reg.th_en && held_ok_reg ? CSC_HOLD : CSC_IDLE;
                    end else if (cnt_reg == ($clog2(SETTLE_CYC))'(SETTLE_CYC - 1)) begin
                        state_next = CSC_VALID;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                CSC_VALID: begin
                    if (!on && cfg_reg.th_en) begin
                        state_next = CSC_HOLD;
                        held_next = live_reg;
                        held_ok_next = 1'b1;
                    end else if (!on) begin
                        state_next = CSC_IDLE;
                    end
                end
                CSC_HOLD: begin
                    if (!cfg_reg.th_en) begin
                        state_next = CSC_IDLE;
                    end else if (on_rise) begin
                        state_next = CSC_SETTLE;
                        cnt_next = '0;
                    end
                end
                default: begin
                    state_next = CSC_IDLE;
                end
            endcase
        end
        // output selection
        if (cfg_reg.src == CSC_SRC_TEMP) begin
            sense_next = temperature_i;
        end else if (state_next == CSC_VALID) begin
            sense_next = live_reg;
        end else if (state_next == CSC_HOLD) begin
            sense_next = held_next;
        end else begin
            sense_next = 12'h000;
        end
        sync_next = (state_next != CSC_VALID);
    end

    // sequence registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= CSC_IDLE;
            cnt_reg <= '0;
            held_reg <= 12'h000;
            held_ok_reg <= 1'b0;
            live_reg <= 12'h000;
            sense_reg <= 12'h000;
            sync_reg <= 1'b1;
            thr_reg <= OCL_HIGH;
            on_prev_reg <= 2'h0;
            src_prev_reg <= CSC_SRC_NONE;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            held_reg <= held_next;
            held_ok_reg <= held_ok_next;
            live_reg <= live_next;
            sense_reg <= sense_next;
            sync_reg <= sync_next;
            thr_reg <= thr_next;
            on_prev_reg <= channel_on_i;
            src_prev_reg <= cfg_reg.src;
        end
    end

    assign dat_o = rdat_reg;
    assign ack_o = ack_reg;
    assign sense_value_o = sense_reg;
    assign sense_valid_pin_inverted_o = sync_reg;
    assign lower_overcurrent_threshold_o = thr_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic quiet; // no source change, no overcurrent
    assign quiet = cur_sel && !src_chg && !oc;

    property p_temp_route;
        (cfg_reg.src == CSC_SRC_TEMP) |=> (sense_value_o == $past(temperature_i));
    endproperty
    a_temp_route: assert property (p_temp_route) else $error("temperature not routed");
    property p_oc_block;
        oc |=> (sense_valid_pin_inverted_o && sense_value_o == 12'h000);
    endproperty
    a_oc_block: assert property (p_oc_block) else $error("sensing during overcurrent");
    property p_sync_off;
        (quiet && state_reg == CSC_VALID && !on && !cfg_reg.th_en) |=> (sense_value_o == 12'h000);
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("current shown after off");
    property p_th_reset;
        $past(rst_i) |-> !cfg_reg.th_en;
    endproperty
    a_th_reset: assert property (p_th_reset) else $error("hold enable not reset");
    property p_settle;
        (quiet && on && state_reg == CSC_SETTLE
            && cnt_reg == ($clog2(SETTLE_CYC))'(SETTLE_CYC - 1))
            |=> (state_reg == CSC_VALID && !sense_valid_pin_inverted_o);
    endproperty
    a_settle: assert property (p_settle) else $error("sync not low after settle");
    property p_hold_take;
        (quiet && state_reg == CSC_VALID && !on && cfg_reg.th_en)
            |=> (state_reg == CSC_HOLD && held_reg == $past(live_reg));
    endproperty
    a_hold_take: assert property (p_hold_take) else $error("hold sample wrong");
    property p_hold_sync;
        (quiet && state_reg == CSC_VALID && !on && cfg_reg.th_en)
            |=> sense_valid_pin_inverted_o ##1 (sense_valid_pin_inverted_o || on);
    endproperty
    a_hold_sync: assert property (p_hold_sync) else $error("sync not high at hold");
    property p_src_chg;
        src_chg |=> (!held_ok_reg && state_reg == CSC_IDLE);
    endproperty
    a_src_chg: assert property (p_src_chg) else $error("held sample kept");
    property p_hold_stable;
        (state_reg == CSC_HOLD)[*2] |-> $stable(held_reg);
    endproperty
    a_hold_stable: assert property (p_hold_stable) else $error("held value moved");
    property p_thr;
        ratio_reg |=> (lower_overcurrent_threshold_o == OCL_LOW);
    endproperty
    a_thr: assert property (p_thr) else $error("threshold not lowered");
    property p_limit;
        (cur > thr) |=> (live_reg == 12'h000);
    endproperty
    a_limit: assert property (p_limit) else $error("sense above threshold");
    property p_ofp_add;
        (ofp_reg[ch] && ratio_reg && cur <= thr && {1'b0, cur} + {5'h00, random_offset_i} < 13'h1000)
            |=> (live_reg == $past(cur + {4'h0, random_offset_i}));
    endproperty
    a_ofp_add: assert property (p_ofp_add) else $error("offset not added");

    c_valid: cover property (state_reg == CSC_SETTLE ##1 state_reg == CSC_VALID);
    c_hold: cover property (state_reg == CSC_VALID ##1 state_reg == CSC_HOLD);
    c_temp: cover property (cfg_reg.src == CSC_SRC_TEMP);
    c_oc: cover property (state_reg == CSC_VALID && oc);
endmodule : csc_top
`default_nettype wire

// *** tb/csc_host_model.sv ***
// host side model: captures the sense value after each rise of the sync pin
// assumes sense and sync pin are registered outputs on clk_i
`timescale 1ns/1ns
`default_nettype none
module csc_host_model import csc_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // sense pins
    input wire logic [11:0] sense_i,
    input wire logic sync_i,
    // stored measurements
    output logic [11:0] first_o,
    output logic [11:0] second_o,
    output logic [11:0] avg_o
);
    // ------------------------------------
    // capture on sync rise
    // ------------------------------------
    logic sync_reg; // last sync level
    logic rise_reg; // rise seen one edge ago
    // wait one edge after the rise so the held value has landed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_reg <= 1'b1;
            rise_reg <= 1'b0;
            first_o <= 12'h000;
            second_o <= 12'h000;
        end else begin
            sync_reg <= sync_i;
            rise_reg <= sync_i & ~sync_reg;
            if (rise_reg) begin
                first_o <= second_o;
                second_o <= sense_i;
            end
        end
    end
    // average of the last two cancels the offset term
    assign avg_o = 12'(({1'b0, first_o} + {1'b0, second_o}) >> 1);
endmodule : csc_host_model
`default_nettype wire

// *** tb/csc_top_bench.sv ***
// bench for csc_top: table of sync-mode measurements, then hand tests
// assumes the design package and csc_host_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module csc_top_bench import csc_pkg::*;;
    // ------------------------------------
    // signals
    // ------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, dat_o, rd;
    logic ack_o, sync_o;
    logic [1:0] ch_on = 2'b00, ocw = 2'b00;
    logic [11:0] cur0 = 12'h000, cur1 = 12'h055, temp = 12'h000;
    logic [7:0] offs = 8'h00;
    logic [11:0] sense_o, thr_o, h_first, h_second, h_avg;
    int n_errors = 0, checks_done = 0, n;
    typedef struct {
        logic k; // channel
        logic r; // ratio bit, 1 = low_current_ratio
        logic p; // offset polarity
        logic [11:0] c; // load current
        logic [7:0] o; // random offset
        logic [11:0] e; // expected sense value
    } csc_row_type;
    csc_row_type rows [7] = '{
        '{1'b0, 1'b0, 1'b1, 12'h400, 8'h10, 12'h104},
        '{1'b0, 1'b0, 1'b0, 12'h400, 8'h10, 12'h0FC},
        '{1'b0, 1'b1, 1'b1, 12'h200, 8'h20, 12'h220},
        '{1'b0, 1'b1, 1'b0, 12'h010, 8'h20, 12'h000},
        '{1'b1, 1'b1, 1'b1, 12'h401, 8'h00, 12'h000},
        '{1'b1, 1'b0, 1'b1, 12'hC00, 8'hFF, 12'h33F},
        '{1'b1, 1'b1, 1'b0, 12'h300, 8'h40, 12'h2C0}};
    // ------------------------------------
    // design and host model
    // ------------------------------------
    csc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .channel_on_i(ch_on), .overcurrent_window_i(ocw), .load_current_0_i(cur0),
        .load_current_1_i(cur1), .temperature_i(temp), .random_offset_i(offs),
        .sense_value_o(sense_o), .sense_valid_pin_inverted_o(sync_o),
        .lower_overcurrent_threshold_o(thr_o));
    csc_host_model host (.clk_i(clk_i), .rst_i(rst_i), .sense_i(sense_o),
        .sync_i(sync_o), .first_o(h_first), .second_o(h_second), .avg_o(h_avg));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // ------------------------------------
    // tasks
    // ------------------------------------
    task automatic finish_test();
        $display("checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string s);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, s, got, exp);
        end
    endtask : chk_val
    task automatic chk_pin(input logic got, input logic exp, input string s);
        chk_val({31'h0, got}, {31'h0, exp}, s);
    endtask : chk_pin
    // classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (k >= 50) chk_pin(1'b0, 1'b1, "no ack");
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    // switch a channel on and count edges until the sync pin falls
    task automatic on_ch(input int c, output int cnt);
        @(posedge clk_i);
        ch_on[c] <= 1'b1;
        cnt = 0;
        do begin
            @(posedge clk_i);
            cnt++;
        end while (sync_o !== 1'b0 && cnt < 400);
    endtask : on_ch
    task automatic off_ch(input int c);
        @(posedge clk_i);
        ch_on[c] <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask : off_ch
    // ------------------------------------
    // watchdog: the run needs some 2300 cycles
    // ------------------------------------
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_val({20'h0, sense_o}, 32'h0, "reset sense");
        chk_pin(sync_o, 1'b1, "reset sync");
        chk_val({20'h0, thr_o}, {20'h0, OCL_HIGH}, "reset threshold");
        wb(1'b0, GEN_CFG_ADR, 32'h0);
        chk_val(rd, 32'h0, "cfg reset");
        wb(1'b0, 8'h14, 32'h0);
        chk_val(rd, 32'h0, "unmapped read");
        $display("test reset done");
        foreach (rows[i]) begin
            wb(1'b1, OC_CFG_ADR, {31'h0, rows[i].r});
            wb(1'b1, rows[i].k ? RETRY1_ADR : RETRY0_ADR, {23'h0, rows[i].p, 8'h00});
            if (rows[i].k) begin
                cur1 <= rows[i].c;
            end else begin
                cur0 <= rows[i].c;
            end
            offs <= rows[i].o;
            wb(1'b1, GEN_CFG_ADR, rows[i].k ? 32'h2 : 32'h1);
            on_ch(rows[i].k, n);
            chk_pin(n >= SETTLE_CYC && n <= SETTLE_CYC + 4, 1'b1, "settle time");
            repeat (5) @(posedge clk_i);
            chk_val({20'h0, sense_o}, {20'h0, rows[i].e}, "sense");
            chk_val({20'h0, thr_o}, {20'h0, rows[i].r ? OCL_LOW : OCL_HIGH}, "thr");
            chk_pin(sync_o, 1'b0, "sync on");
            off_ch(rows[i].k);
            chk_val({20'h0, sense_o}, 32'h0, "sense off");
            chk_pin(sync_o, 1'b1, "sync off");
        end
        $display("test table done");
        wb(1'b1, GEN_CFG_ADR, 32'h3);
        temp <= 12'h123;
        repeat (5) @(posedge clk_i);
        chk_val({20'h0, sense_o}, 32'h123, "temperature");
        chk_pin(sync_o, 1'b1, "sync temp");
        $display("test temperature done");
        wb(1'b1, OC_CFG_ADR, 32'h0);
        wb(1'b1, GEN_CFG_ADR, 32'h1);
        cur0 <= 12'h400;
        offs <= 8'h10;
        on_ch(0, n);
        ocw[0] <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk_val({20'h0, sense_o}, 32'h0, "sense in window");
        chk_pin(sync_o, 1'b1, "sync in window");
        ocw[0] <= 1'b0;
        off_ch(0);
        $display("test overcurrent done");
        // fresh off/on after temperature sensing before trusting a hold value
        wb(1'b1, RETRY0_ADR, 32'h100);
        wb(1'b1, GEN_CFG_ADR, 32'h5);
        on_ch(0, n);
        // a few cycles off keeps the switching rate far above the hold limit
        off_ch(0);
        chk_val({20'h0, sense_o}, 32'h104, "held");
        chk_pin(sync_o, 1'b1, "sync hold");
        wb(1'b0, STATUS_ADR, 32'h0);
        chk_val(rd, 32'h104F, "status hold");
        wb(1'b1, RETRY0_ADR, 32'h0);
        repeat (5) @(posedge clk_i);
        chk_val({20'h0, sense_o}, 32'h104, "held after pol");
        on_ch(0, n);
        off_ch(0);
        chk_val({20'h0, sense_o}, 32'h0FC, "held pol 0");
        chk_val({8'h0, h_first, h_second}, 32'h1040FC, "host pair");
        chk_val({20'h0, h_avg}, 32'h100, "host average");
        wb(1'b1, GEN_CFG_ADR, 32'h6);
        repeat (5) @(posedge clk_i);
        chk_val({20'h0, sense_o}, 32'h0, "held dropped");
        $display("test hold done");
        // reset again with hold mode enabled: it must fall back to sync mode
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_pin(sync_o, 1'b1, "sync after reset");
        wb(1'b0, GEN_CFG_ADR, 32'h0);
        chk_val(rd, 32'h0, "cfg after reset");
        $display("test second reset done");
        finish_test();
    end
endmodule : csc_top_bench
`default_nettype wire
